// ---- design/pscr_defs.svh ----
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH
// How it works
// - Strap decode used only while source select low; rate strap used at either level
// - Upper eq level 0 gives codes 00..03
// - Upper eq level R gives 07,15,0B,0F
// - Upper eq float gives 55,1F,2F,3F
// - Upper eq level 1 gives AA,7F,BF,FF
// - Swing strap picks 0.7, 1.2, 1.0 volts
// - Deemphasis 0, -6, -3.5, -9 dB per level
// - Swing level 1 pairs 1.1/1.3 V with deemphasis
// - Rate strap float applies settings all generations
// - Probe strap 0: termination off, no probing
// - Probe strap 1: termination on, no probing
// - Strap R: probe every 12 ms, quit 600 ms
// - Strap float: probe every 12 ms until found
// - Auto modes: termination only after receiver found
// - Presence pulse of 5 us restarts detection
// - Presence high powers down; 5 us resets detection
// - Threshold strap maps to 10,01,00,11 codes
// - Threshold code drives analog assert/deassert pair
// - Straps arrive resolved to four levels
`define PSCR_CLK_MHZ     100
`define PSCR_PROBE_MS    12
`define PSCR_GIVEUP_MS   600
`define PSCR_PDRST_US    5
`define PSCR_PDRST_CYC   (`PSCR_PDRST_US * `PSCR_CLK_MHZ)
`define PSCR_PROBE_CYC   (`PSCR_PROBE_MS * 1000 * `PSCR_CLK_MHZ)
`define PSCR_GIVEUP_CYC  (`PSCR_GIVEUP_MS * 1000 * `PSCR_CLK_MHZ)
`define PSCR_ADR_EQ      4'h0
`define PSCR_ADR_TX      4'h4
`define PSCR_ADR_STAT    4'h8
`define PSCR_EQA_LSB     0
`define PSCR_EQB_LSB     8
`define PSCR_SWA_LSB     0
`define PSCR_DEA_LSB     4
`define PSCR_SWB_LSB     8
`define PSCR_DEB_LSB     12
`define PSCR_THR_LSB     16
`define PSCR_MODE_LSB    20
`define PSCR_EQ_RST      32'h0000_0000
`define PSCR_TX_RST      32'h0020_0101
`endif

// ---- design/pscr_pkg.sv ----
package pscr_pkg;
	// Resolved four-level strap encoding
	typedef enum logic [1:0] {
		LVL_0 = 2'h0,
		LVL_R = 2'h1,
		LVL_F = 2'h2,
		LVL_1 = 2'h3
	} pscr_lvl_e;
	// Output swing codes
	typedef enum logic [2:0] {
		SW_0P7 = 3'h0,
		SW_1P0 = 3'h1,
		SW_1P1 = 3'h2,
		SW_1P2 = 3'h3,
		SW_1P3 = 3'h4
	} pscr_swing_e;
	// De-emphasis codes
	typedef enum logic [2:0] {
		DE_0   = 3'h0,
		DE_1P5 = 3'h1,
		DE_3P5 = 3'h2,
		DE_6   = 3'h3,
		DE_9   = 3'h4
	} pscr_dem_e;
	// Detection states, Gray along wait-probe-found
	typedef enum logic [2:0] {
		DET_WAIT   = 3'h0,
		DET_PROBE  = 3'h1,
		DET_FOUND  = 3'h3,
		DET_GIVEUP = 3'h2
	} pscr_det_e;
endpackage : pscr_pkg

// ---- design/pscr_top.sv ----
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pscr_defs.svh"
module pscr_top
	import pscr_pkg::*;
#(
	parameter int PROBE_CYC  = `PSCR_PROBE_CYC,
	parameter int GIVEUP_CYC = `PSCR_GIVEUP_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  eqStrapHiSideA,
	input  wire logic [1:0]  eqStrapLoSideA,
	input  wire logic [1:0]  eqStrapHiSideB,
	input  wire logic [1:0]  eqStrapLoSideB,
	input  wire logic [1:0]  swingStrap,
	input  wire logic [1:0]  deemphStrapSideA,
	input  wire logic [1:0]  deemphStrapSideB,
	input  wire logic [1:0]  farRxProbeStrap,
	input  wire logic [1:0]  sigDetThresholdStrap,
	input  wire logic [1:0]  rateStrap,
	input  wire logic        configSourceSelect,
	input  wire logic        presence_n,
	input  wire logic        probeAck,
	input  wire logic        farTermSensed,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [7:0]  eqCodeA,
	output logic      [7:0]  eqCodeB,
	output pscr_swing_e      swingA,
	output pscr_swing_e      swingB,
	output pscr_dem_e        deemphA,
	output pscr_dem_e        deemphB,
	output logic      [3:0]  sigDetThr,
	output logic             deemphAllRates,
	output logic             termEnable,
	output logic             powerDown,
	output logic             driverEnable,
	output logic             probeReq
);
	localparam int PD_CYC = `PSCR_PDRST_CYC;

	// Equalizer table, upper strap selects row
	function automatic logic [7:0] eqMap(input logic [1:0] hi, input logic [1:0] lo);
		case ({hi, lo})
			4'h0: eqMap = 8'h00;
			4'h1: eqMap = 8'h01;
			4'h2: eqMap = 8'h02;
			4'h3: eqMap = 8'h03;
			4'h4: eqMap = 8'h07;
			4'h5: eqMap = 8'h15;
			4'h6: eqMap = 8'h0b;
			4'h7: eqMap = 8'h0f;
			4'h8: eqMap = 8'h55;
			4'h9: eqMap = 8'h1f;
			4'ha: eqMap = 8'h2f;
			4'hb: eqMap = 8'h3f;
			4'hc: eqMap = 8'haa;
			4'hd: eqMap = 8'h7f;
			4'he: eqMap = 8'hbf;
			default: eqMap = 8'hff;
		endcase
	endfunction : eqMap

	// Swing depends on de-emphasis only at top level
	function automatic pscr_swing_e swMap(input logic [1:0] sw, input logic [1:0] de);
		case (sw)
			LVL_0: swMap = SW_0P7;
			LVL_R: swMap = SW_1P2;
			LVL_F: swMap = SW_1P0;
			default: swMap = (de == LVL_0 || de == LVL_R) ? SW_1P1 : SW_1P3;
		endcase
	endfunction : swMap

	function automatic pscr_dem_e deMap(input logic [1:0] sw, input logic [1:0] de);
		if (sw == LVL_1) begin
			case (de)
				LVL_0: deMap = DE_0;
				LVL_1: deMap = DE_3P5;
				default: deMap = DE_1P5;
			endcase
		end else begin
			case (de)
				LVL_0: deMap = DE_0;
				LVL_R: deMap = DE_6;
				LVL_F: deMap = DE_3P5;
				default: deMap = DE_9;
			endcase
		end
	endfunction : deMap

	// Same two-bit code drives both threshold pairs
	function automatic logic [3:0] thrMap(input logic [1:0] t);
		case (t)
			LVL_0: thrMap = 4'ha;
			LVL_R: thrMap = 4'h5;
			LVL_F: thrMap = 4'h0;
			default: thrMap = 4'hf;
		endcase
	endfunction : thrMap

	// Captured straps; levels already resolved off-chip
	logic [1:0]  sEqHiA_reg, sEqLoA_reg, sEqHiB_reg, sEqLoB_reg;
	logic [1:0]  sSw_reg, sDeA_reg, sDeB_reg, sMode_reg, sThr_reg, sRate_reg;
	logic        capValid_reg;
	logic [31:0] eqReg_reg, txReg_reg;
	pscr_det_e   det_reg, det_next;
	logic        probe_next;
	logic [31:0] periodCnt_reg, periodCnt_next;
	logic [31:0] giveCnt_reg, giveCnt_next;
	logic [31:0] pdCnt_reg;

	// Capture once after release so a wiggling strap cannot glitch config
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			capValid_reg <= 1'b0;
			{sEqHiA_reg, sEqLoA_reg, sEqHiB_reg, sEqLoB_reg} <= 8'h00;
			{sSw_reg, sDeA_reg, sDeB_reg} <= 6'h00;
			{sMode_reg, sThr_reg, sRate_reg} <= 6'h00;
		end else if (!capValid_reg) begin
			capValid_reg <= 1'b1;
			{sEqHiA_reg, sEqLoA_reg} <= {eqStrapHiSideA, eqStrapLoSideA};
			{sEqHiB_reg, sEqLoB_reg} <= {eqStrapHiSideB, eqStrapLoSideB};
			{sSw_reg, sDeA_reg, sDeB_reg} <= {swingStrap, deemphStrapSideA, deemphStrapSideB};
			{sMode_reg, sThr_reg, sRate_reg} <= {farRxProbeStrap, sigDetThresholdStrap, rateStrap};
		end
	end

	// Wishbone decode and byte-lane write mask
	wire        wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wbWr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // Lands where master sees ack
	wire        selEq   = wb_adr_i == `PSCR_ADR_EQ;
	wire        selTx   = wb_adr_i == `PSCR_ADR_TX;
	wire        selSt   = wb_adr_i == `PSCR_ADR_STAT;
	wire [31:0] wMask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] eqWr    = ((eqReg_reg & ~wMask) | (wb_dat_i & wMask)) & 32'h0000_ffff;
	wire [31:0] txWr    = ((txReg_reg & ~wMask) | (wb_dat_i & wMask)) & 32'h0037_7777;
	wire [31:0] statVal = {24'h0, 2'h0, driverEnable, powerDown, termEnable, 3'(det_reg)};
	wire [31:0] rdVal   = selEq ? eqReg_reg : selTx ? txReg_reg : selSt ? statVal : 32'h0;

	// One-wait-state slave; unmapped reads zero, writes dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0;
			eqReg_reg <= `PSCR_EQ_RST;
			txReg_reg <= `PSCR_TX_RST;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= wbReq ? rdVal : 32'h0;
			if (wbWr && selEq)
				eqReg_reg <= eqWr;
			if (wbWr && selTx)
				txReg_reg <= txWr;
		end
	end

	// Source selection: straps when low, registers when high
	wire        useReg = configSourceSelect;
	wire [1:0]  mode   = useReg ? txReg_reg[`PSCR_MODE_LSB +: 2] : sMode_reg;
	wire        autoMd = mode == LVL_R || mode == LVL_F;
	wire        limMd  = mode == LVL_R;
	wire [7:0]  eqA    = useReg ? eqReg_reg[`PSCR_EQA_LSB +: 8] : eqMap(sEqHiA_reg, sEqLoA_reg);
	wire [7:0]  eqB    = useReg ? eqReg_reg[`PSCR_EQB_LSB +: 8] : eqMap(sEqHiB_reg, sEqLoB_reg);
	wire [2:0]  swA    = useReg ? txReg_reg[`PSCR_SWA_LSB +: 3] : 3'(swMap(sSw_reg, sDeA_reg));
	wire [2:0]  swB    = useReg ? txReg_reg[`PSCR_SWB_LSB +: 3] : 3'(swMap(sSw_reg, sDeB_reg));
	wire [2:0]  deA    = useReg ? txReg_reg[`PSCR_DEA_LSB +: 3] : 3'(deMap(sSw_reg, sDeA_reg));
	wire [2:0]  deB    = useReg ? txReg_reg[`PSCR_DEB_LSB +: 3] : 3'(deMap(sSw_reg, sDeB_reg));
	wire [3:0]  thr    = useReg ? txReg_reg[`PSCR_THR_LSB +: 4] : thrMap(sThr_reg);

	// Presence held high long enough resets detection
	wire pdHit   = presence_n && pdCnt_reg == 32'(PD_CYC - 1);
	wire restart = pdHit || !autoMd || !capValid_reg;
	wire running = !presence_n;

	always_ff @(posedge clk) begin
		if (sys_rst || !presence_n)
			pdCnt_reg <= 32'h0;
		else if (pdCnt_reg != 32'(PD_CYC))
			pdCnt_reg <= pdCnt_reg + 32'h1;
	end

	// Detection sequencer; frozen during a short power-down
	always_comb begin
		det_next       = det_reg;
		probe_next     = probeReq;
		periodCnt_next = periodCnt_reg;
		giveCnt_next   = giveCnt_reg;
		if (restart) begin
			det_next       = DET_WAIT;
			probe_next     = 1'b0;
			periodCnt_next = 32'h0;
			giveCnt_next   = 32'h0;
		end else if (running) begin
			if (det_reg == DET_WAIT || det_reg == DET_PROBE)
				giveCnt_next = giveCnt_reg + 32'h1;
			case (det_reg)
				DET_WAIT: begin
					if (limMd && giveCnt_reg >= 32'(GIVEUP_CYC - 1)) begin
						det_next = DET_GIVEUP;
					end else if (periodCnt_reg == 32'(PROBE_CYC - 1)) begin
						det_next       = DET_PROBE;
						probe_next     = 1'b1;
						periodCnt_next = 32'h0;
					end else begin
						periodCnt_next = periodCnt_reg + 32'h1;
					end
				end
				DET_PROBE: begin
					periodCnt_next = periodCnt_reg + 32'h1;
					if (probeAck) begin
						probe_next = 1'b0;
						det_next   = farTermSensed ? DET_FOUND : DET_WAIT;
					end
				end
				DET_FOUND: det_next = DET_FOUND;
				DET_GIVEUP: det_next = DET_GIVEUP; // Idle until a presence pulse
				default: det_next = DET_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			det_reg       <= DET_WAIT;
			probeReq      <= 1'b0;
			periodCnt_reg <= 32'h0;
			giveCnt_reg   <= 32'h0;
		end else begin
			det_reg       <= det_next;
			probeReq      <= probe_next;
			periodCnt_reg <= periodCnt_next;
			giveCnt_reg   <= giveCnt_next;
		end
	end

	// Termination and power state, registered for clean pins
	wire termNext = running
		&& (mode == LVL_1 || (autoMd && det_next == DET_FOUND));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			termEnable   <= 1'b0;
			powerDown    <= 1'b1;
			driverEnable <= 1'b0;
		end else begin
			termEnable   <= termNext;
			powerDown    <= presence_n;
			driverEnable <= !presence_n;
		end
	end

	// Configuration outputs change only once straps are captured
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eqCodeA        <= 8'h00;
			eqCodeB        <= 8'h00;
			swingA         <= SW_1P0;
			swingB         <= SW_1P0;
			deemphA        <= DE_0;
			deemphB        <= DE_0;
			sigDetThr      <= 4'h0;
			deemphAllRates <= 1'b0;
		end else if (capValid_reg) begin
			eqCodeA        <= eqA;
			eqCodeB        <= eqB;
			swingA         <= pscr_swing_e'(swA);
			swingB         <= pscr_swing_e'(swB);
			deemphA        <= pscr_dem_e'(deA);
			deemphB        <= pscr_dem_e'(deB);
			sigDetThr      <= thr;
			deemphAllRates <= sRate_reg == LVL_F;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_pd_outputs: assert property (presence_n |=> powerDown && !driverEnable && !termEnable)
		else $error("power-down did not isolate pins");
	chk_pd_restart: assert property (pdHit |=> det_reg == DET_WAIT && !probeReq)
		else $error("long presence pulse did not reset detection");
	chk_manual_hiz: assert property (mode == LVL_0 |=> !termEnable)
		else $error("termination on in manual high-z");
	chk_manual_term: assert property (running && mode == LVL_1 |=> termEnable)
		else $error("termination off in manual 50 ohm");
	chk_auto_hiz: assert property (autoMd && det_next != DET_FOUND |=> !termEnable)
		else $error("termination on before detection");
	chk_found_term: assert property (running && autoMd && det_next == DET_FOUND |=> termEnable)
		else $error("termination off after detection");
	chk_probe_hold: assert property (probeReq && !probeAck && !restart |=> probeReq)
		else $error("probe request dropped before ack");
	chk_probe_rise: assert property ($rose(probeReq)
		|-> $past(periodCnt_reg) == 32'(PROBE_CYC - 1))
		else $error("probe issued off period");
	chk_giveup_end: assert property (running && !restart && limMd && det_reg == DET_WAIT
		&& giveCnt_reg >= 32'(GIVEUP_CYC - 1) |=> det_reg == DET_GIVEUP)
		else $error("limited detection did not give up");
	chk_eq_table: assert property (capValid_reg && !useReg && sEqHiA_reg == LVL_R
		&& sEqLoA_reg == LVL_R |=> eqCodeA == 8'h15)
		else $error("equalizer code wrong for R/R");
	chk_swing_top: assert property (capValid_reg && !useReg && sSw_reg == LVL_1
		&& sDeA_reg == LVL_F |=> swingA == SW_1P3 && deemphA == DE_1P5)
		else $error("top swing pairing wrong");
	chk_thr_code: assert property (capValid_reg && !useReg && sThr_reg == LVL_0
		|=> sigDetThr == 4'ha)
		else $error("threshold code wrong");
	chk_reg_source: assert property (capValid_reg && useReg
		|=> eqCodeB == $past(eqReg_reg[15:8]))
		else $error("register source not applied");
	chk_wb_ack: assert property (wbReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not single cycle");

	cov_found: cover property (det_reg == DET_PROBE ##1 det_reg == DET_FOUND);
	cov_giveup: cover property (det_reg == DET_WAIT ##1 det_reg == DET_GIVEUP);
	cov_restart: cover property (det_reg == DET_FOUND ##1 pdHit);
	cov_wr: cover property (wbWr && selTx);
endmodule : pscr_top

// ---- verif/pscr_far_model.sv ----
`timescale 1ns/1ps
module pscr_far_model (
	input  wire logic clk,
	input  wire logic probeReq,
	input  wire logic present,
	input  wire logic slow,
	output logic      probeAck = 1'b0,
	output logic      farTermSensed = 1'b0
);
	logic [3:0] waitCnt = 4'h0;
	// Far receiver answers a probe after a short or a long settle time
	always_ff @(posedge clk) begin
		if (probeReq && !probeAck && waitCnt >= (slow ? 4'h6 : 4'h0)) begin
			probeAck      <= 1'b1;
			farTermSensed <= present;
		end else begin
			probeAck      <= 1'b0;
			farTermSensed <= ~farTermSensed; // Sense is meaningless outside the ack
		end
		waitCnt <= (probeReq && !probeAck) ? waitCnt + 4'h1 : 4'h0;
	end
endmodule : pscr_far_model

// ---- verif/pscr_top_tb_top.sv ----
`timescale 1ns/1ps
module pscr_top_tb_top;
	import pscr_pkg::*;
	logic        clk = 1'b0, sysRst = 1'b1, srcSel = 1'b0, pdReq = 1'b0;
	logic [1:0]  eqHiA = 2'h0, eqLoA = 2'h0, eqHiB = 2'h0, eqLoB = 2'h0, swing = 2'h0;
	logic [1:0]  deemph_strap_side_a = 2'h0, deemph_strap_side_b = 2'h0, probeStrap = 2'h0, thrStrap = 2'h0, rate = 2'h0;
	logic        present = 1'b0, slow = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0, wbDat;
	logic        ack, probeAck, farSense, allRates, term, pd, drvEn, probeReq;
	logic [7:0]  eqA, eqB;
	logic [3:0]  thr;
	pscr_swing_e swA, swB;
	pscr_dem_e   deA, deB;
	int          errCount = 0, checksDone = 0;
	logic [7:0]  eqTab [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0b, 8'h0f,
		8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf, 8'hff};
	pscr_dem_e   deTab [4] = '{DE_0, DE_6, DE_3P5, DE_9};
	logic [3:0]  thrTab [4] = '{4'ha, 4'h5, 4'h0, 4'hf};

	// Short probe period and give-up span keep the run brief
	pscr_top #(.PROBE_CYC(20), .GIVEUP_CYC(100)) i_pscr_top (
		.clk(clk), .sys_rst(sysRst), .eqStrapHiSideA(eqHiA), .eqStrapLoSideA(eqLoA),
		.eqStrapHiSideB(eqHiB), .eqStrapLoSideB(eqLoB), .swingStrap(swing),
		.deemphStrapSideA(deemph_strap_side_a), .deemphStrapSideB(deemph_strap_side_b), .farRxProbeStrap(probeStrap),
		.sigDetThresholdStrap(thrStrap), .rateStrap(rate), .configSourceSelect(srcSel),
		.presence_n(pdReq), .probeAck(probeAck), .farTermSensed(farSense), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(wbDat), .wb_ack_o(ack), .eqCodeA(eqA), .eqCodeB(eqB), .swingA(swA),
		.swingB(swB), .deemphA(deA), .deemphB(deB), .sigDetThr(thr),
		.deemphAllRates(allRates), .termEnable(term), .powerDown(pd), .driverEnable(drvEn),
		.probeReq(probeReq));
	pscr_far_model i_pscr_far_model (.clk(clk), .probeReq(probeReq), .present(present),
		.slow(slow), .probeAck(probeAck), .farTermSensed(farSense));

	// Free-running core clock
	initial begin
		forever #5 clk = ~clk;
	end

	// Expected swing for one strap pair
	function automatic pscr_swing_e swExp(input logic [1:0] s, input logic [1:0] d);
		case (s)
			LVL_0: return SW_0P7;
			LVL_R: return SW_1P2;
			LVL_F: return SW_1P0;
			default: return d[1] ? SW_1P3 : SW_1P1;
		endcase
	endfunction : swExp

	// Expected de-emphasis; the top swing level has its own set
	function automatic pscr_dem_e deExp(input logic [1:0] s, input logic [1:0] d);
		if (s != LVL_1)
			return deTab[d];
		return (d == LVL_0) ? DE_0 : (d == LVL_1) ? DE_3P5 : DE_1P5;
	endfunction : deExp

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results;
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// Wait n edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Straps must be steady before reset releases, they are sampled once
	task automatic rstGo;
		@(posedge clk);
		sysRst <= 1'b1;
		tick(2);
		@(posedge clk);
		sysRst <= 1'b0;
		tick(3);
	endtask : rstGo

	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = wbDat;
		if (n >= 20)
			check("wb_ack_o", 32'(ack), 32'h1);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : wb

	// Count rising edges of the probe request over n cycles
	task automatic probes(input int n, output logic [31:0] c);
		logic prev;
		c = 32'h0;
		prev = probeReq;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (probeReq === 1'b1 && prev !== 1'b1)
				c++;
			prev = probeReq;
		end
	endtask : probes

	// Main sequence
	initial begin
		logic [31:0] q, c;
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		tick(3);
		// Sixteen strap level combinations, straps as resolved levels
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			eqHiA <= i[3:2]; eqLoA <= i[1:0]; eqHiB <= i[1:0]; eqLoB <= i[3:2];
			swing <= i[3:2]; deemph_strap_side_a <= i[1:0]; deemph_strap_side_b <= i[3:2]; thrStrap <= i[1:0]; rate <= i[1:0];
			rstGo();
			check("eqCodeA", 32'(eqA), 32'(eqTab[i]));
			check("eqCodeB", 32'(eqB), 32'(eqTab[{i[1:0], i[3:2]}]));
			check("swingA", 32'(swA), 32'(swExp(i[3:2], i[1:0])));
			check("swingB", 32'(swB), 32'(swExp(i[3:2], i[3:2])));
			check("deemphA", 32'(deA), 32'(deExp(i[3:2], i[1:0])));
			check("deemphB", 32'(deB), 32'(deExp(i[3:2], i[3:2])));
			check("sigDetThr", 32'(thr), 32'(thrTab[i[1:0]]));
			check("deemphAllRates", 32'(allRates), 32'(i[1:0] == 2));
		end
		// Register source overrides straps, strap source returns
		@(posedge clk);
		srcSel <= 1'b1;
		wb(1'b1, 4'h0, 32'h0000_5aa5, q);
		tick(2);
		check("eqCodeA reg", 32'(eqA), 32'h0000_00a5);
		wb(1'b0, 4'h0, 32'h0, q);
		check("eq reg", q, 32'h0000_5aa5);
		wb(1'b0, 4'h4, 32'h0, q);
		check("tx reg", q, 32'h0020_0101);
		wb(1'b0, 4'hc, 32'h0, q);
		check("unmapped", q, 32'h0);
		// Transmit fields from the register: 1.1 V swing, -9 dB on side A
		wb(1'b1, 4'h4, 32'h0020_0042, q);
		tick(2);
		check("swingA reg", 32'(swA), 32'(SW_1P1));
		check("deemphA reg", 32'(deA), 32'(DE_9));
		@(posedge clk);
		srcSel <= 1'b0;
		tick(3);
		check("eqCodeA strap", 32'(eqA), 32'h0000_00ff);
		// Manual modes never probe
		@(posedge clk);
		probeStrap <= LVL_0;
		rstGo();
		probes(100, c);
		check("probes hi-z", c, 32'h0);
		check("term hi-z", 32'(term), 32'h0);
		@(posedge clk);
		probeStrap <= LVL_1;
		rstGo();
		probes(100, c);
		check("probes 50", c, 32'h0);
		check("term 50", 32'(term), 32'h1);
		// Endless probing with a slow far end, then a receiver appears
		@(posedge clk);
		probeStrap <= LVL_F;
		slow <= 1'b1;
		rstGo();
		probes(100, c);
		check("probes float", 32'(c >= 3), 32'h1);
		check("term pre", 32'(term), 32'h0);
		@(posedge clk);
		present <= 1'b1;
		tick(60);
		check("term found", 32'(term), 32'h1);
		probes(100, c);
		check("probes found", c, 32'h0);
		// Status: found state, termination on, drivers on, not powered down
		wb(1'b0, 4'h8, 32'h0, q);
		check("status found", q, 32'h0000_002b);
		// Power-down overrides termination and drivers
		@(posedge clk);
		pdReq <= 1'b1;
		tick(2);
		check("powerDown", 32'(pd), 32'h1);
		check("driverEnable", 32'(drvEn), 32'h0);
		check("term pd", 32'(term), 32'h0);
		@(posedge clk);
		pdReq <= 1'b0;
		// Time-limited probing gives up, a long pulse restarts it
		@(posedge clk);
		probeStrap <= LVL_R;
		present <= 1'b0;
		slow <= 1'b0;
		rstGo();
		probes(300, c);
		check("probes early", 32'(c >= 2), 32'h1);
		probes(100, c);
		check("probes giveup", c, 32'h0);
		@(posedge clk);
		pdReq <= 1'b1;
		tick(510);
		@(posedge clk);
		pdReq <= 1'b0;
		probes(100, c);
		check("probes restart", 32'(c >= 1), 32'h1);
		results();
	end

	// Run takes about 1700 cycles; cut a hang far beyond that
	initial begin
		#100000;
		check("watchdog", 32'h0, 32'h1);
		results();
	end
endmodule : pscr_top_tb_top
